// ==== src/dmem_pkg.sv ====
// Package: data memory map, field positions, reset values and carrier types
package dmem_pkg;
   // Special-function offsets (same in both banks except 40H, control reg in bank 1 only)
   localparam logic [7:0] ALIAS_FIRST_ADDR   = 8'h00;
   localparam logic [7:0] POINTER_FIRST_ADDR = 8'h01;
   localparam logic [7:0] ALIAS_SECOND_ADDR  = 8'h02;
   localparam logic [7:0] POINTER_SECOND_ADDR = 8'h03;
   localparam logic [7:0] BANK_SELECT_ADDR   = 8'h04;
   localparam logic [7:0] PCL_ADDR           = 8'h06;
   localparam logic [7:0] TBL_LOW_ADDR       = 8'h07;
   localparam logic [7:0] TBL_HIGH_PTR_ADDR  = 8'h08;
   localparam logic [7:0] TBL_HIGH_BYTE_ADDR = 8'h09;
   localparam logic [7:0] FLAGS_ADDR         = 8'h0A;
   localparam logic [7:0] EEPROM_CTRL_ADDR   = 8'h40;
   localparam logic [7:0] GP_START_ADDR      = 8'h80;
   localparam logic [7:0] MEM_BASE_ADDR      = 8'h00;
   // Status register field positions
   localparam int CARRY_BIT   = 0;
   localparam int HALF_BIT    = 1;
   localparam int ZERO_BIT    = 2;
   localparam int OVF_BIT     = 3;
   localparam int PDF_BIT     = 4;
   localparam int TO_BIT      = 5;
   localparam logic [7:0] ARITH_MASK = 8'h0F;
   // Reset values and alias read value
   localparam logic       BANK_RESET   = 1'b0;
   localparam logic [7:0] PTR_RESET    = 8'h00;
   localparam logic [7:0] FLAGS_RESET  = 8'h00;
   localparam logic [7:0] ALIAS_READ   = 8'h00;
   // Sizes
   localparam int MEM_WORDS    = 256;
   localparam int MEM_AW       = 9;
   localparam int PC_W         = 12;
   localparam int DUMMY_CYCLES = 1;

   typedef enum logic [2:0] {
      ALU_NONE, ALU_ADD, ALU_SUB, ALU_ROT, ALU_LOGIC
   } alu_kind_t;

   // One data memory access from the core
   typedef struct packed {
      logic       rd;
      logic       wr;
      logic [7:0] addr;
      logic [7:0] wdata;
   } mem_req_t;

   // ALU flag update request
   typedef struct packed {
      alu_kind_t  kind;
      logic [7:0] op_a;
      logic [7:0] op_b;
      logic [7:0] result;
      logic       carry_in;
      logic       rot_carry;
   } alu_upd_t;

   // System events
   typedef struct packed {
      logic wdt_clear;
      logic halt;
      logic wdt_timeout;
      logic power_up;
      logic wdt_reset_pd;
      logic table_read;
      logic [7:0] table_high;
      logic tbl_inc;
      logic tbl_dec;
   } sys_evt_t;
endpackage : dmem_pkg

// ==== src/dmem_ram.sv ====
// Two-bank general purpose storage with registered read data
`timescale 1ns/1ps
module dmem_ram
   import dmem_pkg::*;
(
   // Clock
   input  wire logic              clock,
   // Port
   input  wire logic              we,
   input  wire logic [MEM_AW-1:0] waddr,
   input  wire logic [7:0]        wdata,
   input  wire logic [MEM_AW-1:0] raddr,
   output      logic [7:0]        rdata
);
   logic [7:0] mem [0:(2*MEM_WORDS)-1];

   always_ff @(posedge clock) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
      rdata <= mem[raddr];
   end
endmodule : dmem_ram

// ==== src/banked_data_memory_status.sv ====
// Banked data memory with pointers, bank select, table and status registers
`timescale 1ns/1ps
// Functional notes
// - 256 byte read/write data memory
// - Two banks; shared registers, control reg bank 1
// - Address space starts at 00H
// - Alias access goes to pointed location
// - First pair bank 0; second uses bank select
// - Alias via indirect reads 00H, ignores write
// - Direct access always bank 0
// - Bank select bit 0, upper bits zero
// - Bank reset except watchdog power-down reset
// - Pointers are real read/write registers
// - Counter low write jumps, one dummy cycle
// - Table low pointer inc/dec; table high loaded
// - Status write keeps timeout and power-down
// - Carry from add, no borrow, rotate
// - Half carry from low nibble
// - Zero flag on zero result
// - Overflow when carries into/out differ
// - Power-down flag clear/set rules
// - Timeout flag clear/set rules
// - Status never saved automatically
module banked_data_memory_status
   import dmem_pkg::*;
(
   // Clock and reset
   input  wire logic            clock,
   input  wire logic            nrst,
   // Core access
   input  wire mem_req_t        req,
   output      logic [7:0]      rdata_r,
   output      logic            eeprom_ctrl_sel_r,
   // Flag and system updates
   input  wire alu_upd_t        alu,
   input  wire sys_evt_t        evt,
   input  wire logic [PC_W-1:0] pc_cur,
   // Outputs
   output      logic            pc_load_r,
   output      logic [PC_W-1:0] pc_target_r,
   output      logic            dummy_cycle_r,
   output      logic [7:0]      flags_r,
   output      logic            bank_sel_r,
   output      logic [7:0]      tbl_low_r,
   output      logic [7:0]      tbl_high_ptr_r
);
   ////////////////////////////////////////////////////////////////////////
   // Address resolution
   logic [7:0]        ptr_first_r;
   logic [7:0]        ptr_first_nxt;
   logic [7:0]        ptr_second_r;
   logic [7:0]        ptr_second_nxt;
   logic              bank_sel_nxt;
   logic              bank_load_nxt;
   logic [7:0]        tbl_low_nxt;
   logic [7:0]        tbl_high_ptr_nxt;
   logic [7:0]        tbl_high_byte_r;
   logic [7:0]        tbl_high_byte_nxt;
   logic [7:0]        flags_nxt;
   logic [7:0]        rdata_nxt;
   logic              pc_load_nxt;
   logic              dummy_nxt;
   logic              ee_sel_nxt;
   logic [PC_W-1:0]   pc_target_nxt;
   logic [MEM_AW-1:0] eff_addr;
   logic              via_alias;
   logic              alias_hit;
   logic              is_sfr;
   logic [7:0]        off;
   logic              eff_bank;
   logic [7:0]        ram_rdata;
   logic              ram_we;
   logic              rd_sfr_r;
   logic              rd_sfr_nxt;
   logic              rd_zero_r;
   logic              rd_zero_nxt;
   logic [7:0]        sfr_val_r;
   logic [7:0]        sfr_val_nxt;

   always_comb begin
      via_alias = 1'b0;
      off       = req.addr;
      eff_bank  = 1'b0;
      if (req.addr == ALIAS_FIRST_ADDR) begin
         via_alias = 1'b1;
         off       = ptr_first_r;
         eff_bank  = 1'b0;
      end else if (req.addr == ALIAS_SECOND_ADDR) begin
         via_alias = 1'b1;
         off       = ptr_second_r;
         eff_bank  = bank_sel_r;
      end
      // A pointer that names an alias reaches no real storage
      alias_hit = via_alias && (off == ALIAS_FIRST_ADDR
                             || off == ALIAS_SECOND_ADDR);
      // Control register at 40H only exists in bank 1
      is_sfr   = (off < GP_START_ADDR)
               && !(off == EEPROM_CTRL_ADDR && eff_bank);
      eff_addr = is_sfr ? {1'b0, off} : {eff_bank, off};
   end

   assign ram_we = req.wr && !alias_hit && !is_sfr;

   dmem_ram u_ram (
      .clock (clock),
      .we    (ram_we),
      .waddr (eff_addr),
      .wdata (req.wdata),
      .raddr (eff_addr),
      .rdata (ram_rdata)
   );

   ////////////////////////////////////////////////////////////////////////
   // Special function registers and flags
   logic [8:0] sum9;
   logic [4:0] sum5;
   logic [7:0] sum7;
   logic       c_out;
   logic       c_into7;

   always_comb begin
      ptr_first_nxt     = ptr_first_r;
      ptr_second_nxt    = ptr_second_r;
      bank_sel_nxt      = bank_sel_r;
      tbl_low_nxt       = tbl_low_r;
      tbl_high_ptr_nxt  = tbl_high_ptr_r;
      tbl_high_byte_nxt = tbl_high_byte_r;
      flags_nxt         = flags_r;
      pc_load_nxt       = 1'b0;
      dummy_nxt         = 1'b0;
      pc_target_nxt     = pc_target_r;
      ee_sel_nxt        = 1'b0;
      sum9 = 9'h000;
      sum5 = 5'h00;
      sum7 = 8'h00;
      c_out = 1'b0;
      c_into7 = 1'b0;
      // ALU flag updates
      case (alu.kind)
         ALU_ADD, ALU_SUB: begin
            sum9 = {1'b0, alu.op_a} + {1'b0, alu.op_b}
                 + {8'h00, alu.carry_in};
            sum5 = {1'b0, alu.op_a[3:0]} + {1'b0, alu.op_b[3:0]}
                 + {4'h0, alu.carry_in};
            sum7 = {1'b0, alu.op_a[6:0]} + {1'b0, alu.op_b[6:0]}
                 + {7'h00, alu.carry_in};
            c_out   = sum9[8];
            c_into7 = sum7[7];
            // Subtract is fed as a + ~b + 1, carry equals no borrow
            flags_nxt[CARRY_BIT] = c_out;
            flags_nxt[HALF_BIT]  = sum5[4];
            flags_nxt[ZERO_BIT]  = (alu.result == 8'h00);
            flags_nxt[OVF_BIT]   = c_into7 ^ c_out;
         end
         ALU_ROT: begin
            flags_nxt[CARRY_BIT] = alu.rot_carry;
         end
         ALU_LOGIC: begin
            flags_nxt[ZERO_BIT] = (alu.result == 8'h00);
         end
         default: begin
         end
      endcase
      // Register writes (direct or through an alias)
      // Unlisted special offsets take no write
      if (req.wr && is_sfr && !alias_hit) begin
         if (off == POINTER_FIRST_ADDR) begin
            ptr_first_nxt = req.wdata;
         end else if (off == POINTER_SECOND_ADDR) begin
            ptr_second_nxt = req.wdata;
         end else if (off == BANK_SELECT_ADDR) begin
            bank_sel_nxt = req.wdata[0];
         end else if (off == PCL_ADDR) begin
            pc_load_nxt   = 1'b1;
            dummy_nxt     = 1'b1;
            pc_target_nxt = {pc_cur[PC_W-1:8], req.wdata};
         end else if (off == TBL_LOW_ADDR) begin
            tbl_low_nxt = req.wdata;
         end else if (off == TBL_HIGH_PTR_ADDR) begin
            tbl_high_ptr_nxt = req.wdata;
         end else if (off == FLAGS_ADDR) begin
            flags_nxt = (flags_r & ~ARITH_MASK)
                      | (req.wdata & ARITH_MASK);
         end
      end
      if (req.addr == EEPROM_CTRL_ADDR || (via_alias && !is_sfr
          && off == EEPROM_CTRL_ADDR)) begin
         ee_sel_nxt = via_alias && eff_bank && (req.rd || req.wr);
      end
      // A hardware step of the table pointer wins over a write
      if (evt.tbl_inc) begin
         tbl_low_nxt = tbl_low_r + 8'h01;
      end else if (evt.tbl_dec) begin
         tbl_low_nxt = tbl_low_r - 8'h01;
      end
      if (evt.table_read) begin
         tbl_high_byte_nxt = evt.table_high;
      end
      // System flags: set wins over clear
      if (evt.power_up || evt.wdt_clear) begin
         flags_nxt[PDF_BIT] = 1'b0;
      end
      if (evt.halt) begin
         flags_nxt[PDF_BIT] = 1'b1;
      end
      if (evt.power_up || evt.wdt_clear || evt.halt) begin
         flags_nxt[TO_BIT] = 1'b0;
      end
      if (evt.wdt_timeout) begin
         flags_nxt[TO_BIT] = 1'b1;
      end
      // Unused upper status bits read as zero
      flags_nxt[7:6] = 2'b00;
      if (evt.power_up) begin
         bank_sel_nxt = BANK_RESET;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read path
   always_comb begin
      rd_sfr_nxt  = is_sfr;
      rd_zero_nxt = alias_hit;
      sfr_val_nxt = 8'h00;
      if (off == POINTER_FIRST_ADDR) begin
         sfr_val_nxt = ptr_first_r;
      end else if (off == POINTER_SECOND_ADDR) begin
         sfr_val_nxt = ptr_second_r;
      end else if (off == BANK_SELECT_ADDR) begin
         sfr_val_nxt = {7'h00, bank_sel_r};
      end else if (off == PCL_ADDR) begin
         sfr_val_nxt = pc_cur[7:0];
      end else if (off == TBL_LOW_ADDR) begin
         sfr_val_nxt = tbl_low_r;
      end else if (off == TBL_HIGH_PTR_ADDR) begin
         sfr_val_nxt = tbl_high_ptr_r;
      end else if (off == TBL_HIGH_BYTE_ADDR) begin
         sfr_val_nxt = tbl_high_byte_r;
      end else if (off == FLAGS_ADDR) begin
         sfr_val_nxt = flags_r;
      end
   end

   // Captured values are chosen one edge after the request
   always_comb begin
      if (rd_zero_r) begin
         rdata_nxt = ALIAS_READ;
      end else if (rd_sfr_r) begin
         rdata_nxt = sfr_val_r;
      end else begin
         rdata_nxt = ram_rdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Registers
   always_ff @(posedge clock) begin
      if (!nrst) begin
         ptr_first_r       <= PTR_RESET;
         ptr_second_r      <= PTR_RESET;
         tbl_low_r         <= PTR_RESET;
         tbl_high_ptr_r    <= PTR_RESET;
         tbl_high_byte_r   <= PTR_RESET;
         flags_r           <= FLAGS_RESET;
         pc_load_r         <= 1'b0;
         dummy_cycle_r     <= 1'b0;
         pc_target_r       <= '0;
         eeprom_ctrl_sel_r <= 1'b0;
         rd_sfr_r          <= 1'b0;
         rd_zero_r         <= 1'b0;
         sfr_val_r         <= 8'h00;
         rdata_r           <= 8'h00;
      end else begin
         ptr_first_r       <= ptr_first_nxt;
         ptr_second_r      <= ptr_second_nxt;
         tbl_low_r         <= tbl_low_nxt;
         tbl_high_ptr_r    <= tbl_high_ptr_nxt;
         tbl_high_byte_r   <= tbl_high_byte_nxt;
         flags_r           <= flags_nxt;
         pc_load_r         <= pc_load_nxt;
         dummy_cycle_r     <= dummy_nxt;
         pc_target_r       <= pc_target_nxt;
         eeprom_ctrl_sel_r <= ee_sel_nxt;
         rd_sfr_r          <= rd_sfr_nxt;
         rd_zero_r         <= rd_zero_nxt;
         sfr_val_r         <= sfr_val_nxt;
         rdata_r           <= rdata_nxt;
      end
   end

   // Bank keeps its value on a watchdog reset from power-down
   always_comb begin
      bank_load_nxt = bank_sel_nxt;
      if (!nrst) begin
         bank_load_nxt = evt.wdt_reset_pd ? bank_sel_r : BANK_RESET;
      end
   end

   always_ff @(posedge clock) begin
      bank_sel_r <= bank_load_nxt;
   end
endmodule : banked_data_memory_status

// ==== verification/dmem_checker.sv ====
// Checker: port-level properties of the banked data memory
`timescale 1ns/1ps
module dmem_checker
   import dmem_pkg::*;
(
   // Clock and reset
   input wire logic            clock,
   input wire logic            nrst,
   // Core side
   input wire mem_req_t        req,
   input wire alu_upd_t        alu,
   input wire sys_evt_t        evt,
   input wire logic [PC_W-1:0] pc_cur,
   // Results
   input wire logic            eeprom_ctrl_sel_r,
   input wire logic            pc_load_r,
   input wire logic [PC_W-1:0] pc_target_r,
   input wire logic            dummy_cycle_r,
   input wire logic [7:0]      flags_r,
   input wire logic            bank_sel_r,
   input wire logic [7:0]      tbl_low_r
);
   logic [8:0]      sum9;
   logic [PC_W-1:0] tgt;
   logic            cy, zr, wr_pcl, wr_bank, wr_flag, sel_why;
   assign sum9 = {1'b0, alu.op_a} + {1'b0, alu.op_b} + 9'(alu.carry_in);
   assign cy = sum9[8];
   assign zr = alu.result == 8'h00;
   assign tgt = {pc_cur[PC_W-1:8], req.wdata};
   assign wr_pcl = req.wr && req.addr == PCL_ADDR;
   assign wr_bank = req.wr && req.addr == BANK_SELECT_ADDR;
   assign wr_flag = req.wr && req.addr == FLAGS_ADDR;
   assign sel_why = (req.rd || req.wr) && req.addr == ALIAS_SECOND_ADDR
                    && bank_sel_r;
   default clocking @(posedge clock);
   endclocking
   default disable iff (!nrst);
   ////////////////////////////////////////////////////////////////////////
   pcl_jump_a: assert property (wr_pcl |=> pc_load_r && dummy_cycle_r
      && pc_target_r == $past(tgt)) else $error("pcl jump wrong");
   bank_wr_a: assert property (wr_bank && !evt.power_up |=>
      {7'h00, bank_sel_r} == ($past(req.wdata) & 8'h01))
      else $error("bank write wrong");
   flag_wr_a: assert property (wr_flag && alu.kind == ALU_NONE
      && evt == '0 |=> flags_r == (($past(flags_r) & 8'h30)
      | ($past(req.wdata) & ARITH_MASK))) else $error("status write wrong");
   halt_pd_a: assert property (evt.halt && !evt.wdt_timeout
      |=> flags_r[5:4] == 2'b01) else $error("halt flags wrong");
   tmo_set_a: assert property (evt.wdt_timeout |=> flags_r[TO_BIT])
      else $error("timeout flag not set");
   wdt_clr_a: assert property (evt.wdt_clear && !evt.halt
      && !evt.wdt_timeout |=> flags_r[5:4] == 2'b00) else $error("clear bad");
   carry_upd_a: assert property (alu.kind inside {ALU_ADD, ALU_SUB}
      && !wr_flag |=> flags_r[CARRY_BIT] == $past(cy)) else $error("carry");
   zero_upd_a: assert property (
      alu.kind inside {ALU_ADD, ALU_SUB, ALU_LOGIC} && !wr_flag
      |=> flags_r[ZERO_BIT] == $past(zr)) else $error("zero");
   tbl_inc_a: assert property (evt.tbl_inc |=>
      tbl_low_r == $past(tbl_low_r) + 8'h01) else $error("table step wrong");
   ctrl_sel_a: assert property (eeprom_ctrl_sel_r |-> $past(sel_why))
      else $error("control select without cause");
   bank_rst_a: assert property (disable iff (1'b0)
      !nrst && !evt.wdt_reset_pd |=> !bank_sel_r) else $error("bank reset");
   cover property (pc_load_r);
   cover property (eeprom_ctrl_sel_r);
   cover property (evt.wdt_timeout ##3 evt.halt);
endmodule : dmem_checker

bind banked_data_memory_status dmem_checker u_chk (.clock(clock),
   .nrst(nrst), .req(req), .alu(alu), .evt(evt), .pc_cur(pc_cur),
   .eeprom_ctrl_sel_r(eeprom_ctrl_sel_r), .pc_load_r(pc_load_r),
   .pc_target_r(pc_target_r), .dummy_cycle_r(dummy_cycle_r),
   .flags_r(flags_r), .bank_sel_r(bank_sel_r), .tbl_low_r(tbl_low_r));

// ==== verification/core_model.sv ====
// Partner: instruction core issuing accesses, flag updates and events
`timescale 1ns/1ps
module core_model
   import dmem_pkg::*;
#(
   parameter logic [PC_W-1:0] PC_NOW = 12'hA37
)
(
   // Clock
   input wire logic        clock,
   // Requests
   output mem_req_t        req,
   output alu_upd_t        alu,
   output sys_evt_t        evt,
   output logic [PC_W-1:0] pc_cur,
   // Answer
   input wire logic [7:0]  rdata_r
);
   initial begin
      req = '0;
      alu = '0;
      evt = '0;
      pc_cur = PC_NOW;
   end
   // Released lines show the inverse so stale values never match
   task bus(input logic rd, wr, input logic [7:0] a, d, output logic [7:0] q);
      @(negedge clock);
      req = '{rd: rd, wr: wr, addr: a, wdata: d};
      @(negedge clock);
      req = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
      @(negedge clock);
      q = rdata_r;
   endtask : bus
   task alu_op(input alu_upd_t u);
      @(negedge clock);
      alu = u;
      @(negedge clock);
      alu = '0;
      @(negedge clock);
   endtask : alu_op
   task pulse(input sys_evt_t e);
      @(negedge clock);
      evt = e;
      @(negedge clock);
      evt = '0;
      @(negedge clock);
   endtask : pulse
   task hold(input sys_evt_t e);
      @(negedge clock);
      evt = e;
   endtask : hold
endmodule : core_model

// ==== verification/tb.sv ====
// Testbench: access-level checks of the banked data memory
`timescale 1ns/1ps
module tb;
   import dmem_pkg::*;
   logic            clock, nrst, sel_r, pc_load_r, dummy_r, bank_sel_r;
   mem_req_t        req;
   alu_upd_t        alu;
   alu_upd_t        u;
   sys_evt_t        evt;
   logic [PC_W-1:0] pc_cur, pc_target_r;
   logic [7:0]      rdata_r, flags_r, tbl_low_r, tbl_high_r, q;
   logic [8:0]      s;
   logic [3:0]      e4;
   int              miscompares, check_count, sel_n, pcl_n, dum_n;
   logic [7:0]      ta [5] = '{8'h0F, 8'h80, 8'h7F, 8'h05, 8'h03};
   logic [7:0]      tv [5] = '{8'h01, 8'h80, 8'h01, 8'hFA, 8'hFA};
   logic            tc [5] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
   banked_data_memory_status u_dut (.clock(clock), .nrst(nrst), .req(req),
      .rdata_r(rdata_r), .eeprom_ctrl_sel_r(sel_r), .alu(alu), .evt(evt),
      .pc_cur(pc_cur), .pc_load_r(pc_load_r), .pc_target_r(pc_target_r),
      .dummy_cycle_r(dummy_r), .flags_r(flags_r), .bank_sel_r(bank_sel_r),
      .tbl_low_r(tbl_low_r), .tbl_high_ptr_r(tbl_high_r));
   core_model u_core (.clock(clock), .req(req), .alu(alu), .evt(evt),
      .pc_cur(pc_cur), .rdata_r(rdata_r));
   initial begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end
   always @(negedge clock) begin
      sel_n += int'(sel_r === 1'b1);
      pcl_n += int'(pc_load_r === 1'b1);
      dum_n += int'(dummy_r === 1'b1);
   end
   ////////////////////////////////////////////////////////////////////////
   task check(input logic [11:0] seen, exp);
      check_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task w(input logic [7:0] a, d);
      u_core.bus(1'b0, 1'b1, a, d, q);
   endtask : w
   task r(input logic [7:0] a, e);
      u_core.bus(1'b1, 1'b0, a, 8'h00, q);
      check(q, e);
   endtask : r
   function logic [3:0] arith(input logic [7:0] a, b, input logic c);
      logic [8:0] t;
      logic [4:0] lo;
      logic [7:0] m;
      t = a + b + c;
      lo = a[3:0] + b[3:0] + c;
      m = a[6:0] + b[6:0] + c;
      return {m[7] ^ t[8], t[7:0] == 8'h00, lo[4], t[8]};
   endfunction : arith
   task tally_and_finish;
      $display("comparisons %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : tally_and_finish
   ////////////////////////////////////////////////////////////////////////
   // Whole run takes under 20 us; allow five times that
   initial begin
      #100000;
      miscompares++;
      tally_and_finish;
   end
   initial begin
      nrst = 1'b0;
      repeat (5) @(negedge clock);
      nrst = 1'b1;
      check(flags_r, 8'h00);
      check(bank_sel_r, 1'b0);
      w(8'h80, 8'hA1);
      w(8'hFF, 8'hB2);
      r(8'h80, 8'hA1);
      r(8'hFF, 8'hB2);
      w(8'h01, 8'h85);
      r(8'h01, 8'h85);
      w(8'h00, 8'h5A);
      r(8'h85, 8'h5A);
      w(8'h90, 8'h11);
      w(8'h04, 8'hFF);
      r(8'h04, 8'h01);
      w(8'h03, 8'h90);
      w(8'h02, 8'hC3);
      r(8'h02, 8'hC3);
      r(8'h90, 8'h11);
      w(8'h01, 8'h90);
      r(8'h00, 8'h11);
      w(8'h03, 8'h04);
      r(8'h02, 8'h01);
      w(8'h01, 8'h02);
      w(8'h00, 8'h77);
      r(8'h00, 8'h00);
      r(8'h03, 8'h04);
      w(8'h03, 8'h40);
      u_core.bus(1'b1, 1'b0, 8'h02, 8'h00, q);
      check(12'(sel_n), 12'h001);
      w(8'h04, 8'h00);
      u_core.bus(1'b1, 1'b0, 8'h02, 8'h00, q);
      check(12'(sel_n), 12'h001);
      w(8'h06, 8'h5C);
      check(pc_target_r, 12'hA5C);
      check(12'(pcl_n), 12'h001);
      check(12'(dum_n), 12'h001);
      w(8'h0A, 8'hFF);
      check(flags_r, 8'h0F);
      u_core.pulse('{wdt_timeout: 1'b1, default: '0});
      u_core.pulse('{halt: 1'b1, default: '0});
      check(flags_r[5:4], 2'b01);
      u_core.pulse('{wdt_timeout: 1'b1, default: '0});
      check(flags_r[5:4], 2'b11);
      w(8'h0A, 8'h00);
      check(flags_r, 8'h30);
      u_core.pulse('{wdt_clear: 1'b1, default: '0});
      check(flags_r[5:4], 2'b00);
      for (int i = 0; i < 5; i++) begin
         s = ta[i] + tv[i] + tc[i];
         u = '{kind: tc[i] ? ALU_SUB : ALU_ADD, op_a: ta[i], op_b: tv[i],
               result: s[7:0], carry_in: tc[i], rot_carry: 1'b0};
         u_core.alu_op(u);
         e4 = arith(ta[i], tv[i], tc[i]);
         check(flags_r[3:0], e4);
      end
      u_core.alu_op('{kind: ALU_ROT, rot_carry: 1'b1, default: '0});
      check(flags_r[CARRY_BIT], 1'b1);
      u_core.alu_op('{kind: ALU_LOGIC, result: 8'h00, default: '0});
      check(flags_r[ZERO_BIT], 1'b1);
      w(8'h07, 8'h10);
      w(8'h08, 8'h0F);
      check(tbl_high_r, 8'h0F);
      u_core.pulse('{tbl_inc: 1'b1, default: '0});
      check(tbl_low_r, 8'h11);
      u_core.pulse('{tbl_dec: 1'b1, default: '0});
      u_core.pulse('{tbl_dec: 1'b1, default: '0});
      check(tbl_low_r, 8'h0F);
      u_core.pulse('{table_read: 1'b1, table_high: 8'hA5, default: '0});
      r(8'h09, 8'hA5);
      w(8'h04, 8'h01);
      u_core.hold('{wdt_reset_pd: 1'b1, default: '0});
      nrst = 1'b0;
      repeat (2) @(negedge clock);
      nrst = 1'b1;
      u_core.hold('0);
      check(bank_sel_r, 1'b1);
      u_core.pulse('{wdt_timeout: 1'b1, default: '0});
      u_core.pulse('{power_up: 1'b1, default: '0});
      check(bank_sel_r, 1'b0);
      check(flags_r[5:4], 2'b00);
      w(8'h04, 8'h01);
      nrst = 1'b0;
      repeat (2) @(negedge clock);
      nrst = 1'b1;
      check(bank_sel_r, 1'b0);
      tally_and_finish;
   end
endmodule : tb
